// ---- hdl/fsp_ctrl.sv ----
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
// Contract
// (RL1) writing store enable arms the store instruction for the next four cycles
// (RL2) store enable alone: store writes the data pair into the page buffer
// (RL3) stores ignore pointer bit 0; loads are byte addressed and use it
// (RL4) store enable clears on completion or four idle cycles; held during erase/write
// (RL5) only the five legal low-bit command patterns take effect
// (RL6) pointer low bits select word in page, high bits select page
// (RL7) target page is latched when an operation starts
// (RL8) lock set ignores the pointer; other stores use it; here re-enable ignores it too
// (RL9) erase: page field plus erase pattern, store within four cycles
// (RL10) erase/write to halting section stalls the cpu; other section stays readable
// (RL11) buffer load: word field selects buffer entry, store within four cycles
// (RL12) page buffer clears after page write, read re-enable and reset
// (RL13) software writes each buffer entry at most once between clears
// (RL14) page write programs buffer contents into the latched page
// (RL15) interrupt enabled: level request while store enable reads zero
// (RL16) erase/write sets busy flag and blocks reads until re-enable; here only readable-section pages set it
// (RL17) lock set programs boot lock bits whose data bits 5..2 are zero
// (RL18) software should point at lock readback and set unused bits
// (RL19) lock programming keeps flash readable and never halts the cpu
// (RL20) eeprom write in progress blocks all commands and readbacks
// (RL21) lock readback: pointer one, lock set armed, load within three cycles
// (RL22) lock set clears on readback, or when its windows run out
// (RL23) starting a buffer load also clears the busy flag
// (RL24) re-enable during buffer loading discards the loaded data
// (RL25) readback returns fuse low at pointer zero, fuse high at three
// (RL26) programmed fuse and lock bits read zero, unprogrammed one
// (RL27) erase, write and lock set are timed by an internal counter
module fsp_ctrl #(
  parameter int PROG_CYCLES = fsp_pkg::PROG_CYCLES,
  // arbitrary neutral fuse contents
  parameter logic [7:0] FUSE_LOW_VALUE = 8'hff,
  parameter logic [7:0] FUSE_HIGH_VALUE = 8'hff
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spm_strobe,
  input wire logic lpm_strobe,
  input wire logic eeprom_write_busy,
  output logic [7:0] lpm_rdata,
  output logic lpm_rvalid,
  output logic selfprog_irq,
  output logic cpu_halt,
  output logic rww_read_block,
  output logic flash_erase_start,
  output logic flash_prog_valid,
  output logic [6:0] flash_prog_page,
  output logic [5:0] flash_prog_word,
  output logic [15:0] flash_prog_data,
  output logic flash_prog_done
);

  typedef struct packed {
    fsp_pkg::fsp_mode_type mode;
    logic [4:0] cmd;
    logic irq_en;
    logic rww_busy;
    logic [2:0] arm_cnt;
    logic [1:0] lpm_cnt;
    logic [15:0] zptr;
    logic [15:0] data;
    logic [7:0] lock;
    logic [6:0] op_page;
    logic op_halt;
    logic [19:0] prog_cnt;
    logic [6:0] stream_idx;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] lpm_data;
    logic lpm_valid;
    logic irq;
    logic erase_start;
    logic fl_valid;
    logic [5:0] fl_word;
    logic [15:0] fl_data;
    logic fl_done;
  } fsp_state_type;

  localparam fsp_state_type ST_RESET = '{
    mode: fsp_pkg::FSP_IDLE,
    lock: fsp_pkg::LOCK_RESET,
    default: '0
  };

  fsp_state_type r;
  fsp_state_type r_nxt;
  fsp_buf_if bif ();

  fsp_page_buf u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .bif(bif)
  );

  function automatic logic legal_cmd(input logic [4:0] c);
    return (c == fsp_pkg::CMD_LOAD) || (c == fsp_pkg::CMD_ERASE) ||
      (c == fsp_pkg::CMD_WRITE) || (c == fsp_pkg::CMD_LOCK) || (c == fsp_pkg::CMD_REEN);
  endfunction : legal_cmd

  function automatic logic [7:0] readback(input logic [15:0] z, input logic [7:0] lock);
    case (z)
      fsp_pkg::ZSEL_FUSE_LO: return FUSE_LOW_VALUE;
      fsp_pkg::ZSEL_LOCK: return lock;
      fsp_pkg::ZSEL_FUSE_HI: return FUSE_HIGH_VALUE;
      default: return fsp_pkg::LOCK_RESET;
    endcase
  endfunction : readback

  logic apb_setup;
  logic wr_ev;
  logic ctl_wr;
  logic spm_ok;
  logic lpm_ok;
  logic [6:0] z_page;
  logic [5:0] z_word;
  logic [7:0] ctl_view;

  assign apb_setup = psel & ~penable;
  assign wr_ev = psel & penable & r.pready & pwrite;
  assign ctl_wr = wr_ev && (paddr == fsp_pkg::OFS_CTL);
  // eeprom busy shuts out every store and load
  assign spm_ok = (r.mode == fsp_pkg::FSP_ARMED) && (r.arm_cnt != 3'h0) && spm_strobe &&
    !eeprom_write_busy; // RL1 RL20
  assign lpm_ok = (r.mode == fsp_pkg::FSP_ARMED) && (r.cmd == fsp_pkg::CMD_LOCK) &&
    (r.lpm_cnt != 2'h0) && lpm_strobe && !eeprom_write_busy; // RL21 RL20
  assign z_page = r.zptr[fsp_pkg::PAGE_LSB +: fsp_pkg::PAGE_BITS]; // RL6
  assign z_word = r.zptr[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_BITS]; // RL6 RL3
  assign ctl_view = {r.irq_en, r.rww_busy, 1'b0, r.cmd};

  always_comb begin
    r_nxt = r;
    bif.wr_en = 1'b0;
    bif.wr_idx = z_word; // RL11
    bif.wr_data = r.data;
    bif.clr = 1'b0;
    bif.rd_idx = r.stream_idx[5:0];
    // apb: answer is prepared in setup so pready and prdata come from flops
    r_nxt.pready = apb_setup;
    r_nxt.pslverr = 1'b0;
    r_nxt.prdata = 32'h0000_0000;
    if (apb_setup) begin
      case (paddr)
        fsp_pkg::OFS_CTL: r_nxt.prdata = {24'h00_0000, ctl_view};
        fsp_pkg::OFS_ZPTR: r_nxt.prdata = {16'h0000, r.zptr};
        fsp_pkg::OFS_DATA: r_nxt.prdata = {16'h0000, r.data};
        fsp_pkg::OFS_LOCK: r_nxt.prdata = {24'h00_0000, r.lock};
        default: r_nxt.pslverr = 1'b1;
      endcase
    end
    r_nxt.lpm_valid = 1'b0;
    r_nxt.erase_start = 1'b0;
    r_nxt.fl_valid = 1'b0;
    r_nxt.fl_done = 1'b0;
    if (wr_ev && (paddr == fsp_pkg::OFS_ZPTR)) begin
      r_nxt.zptr = pwdata[15:0];
    end
    if (wr_ev && (paddr == fsp_pkg::OFS_DATA)) begin
      r_nxt.data = pwdata[15:0];
    end
    if (ctl_wr) begin
      r_nxt.irq_en = pwdata[fsp_pkg::CTL_IRQ_EN_POS];
      // a busy controller keeps its command; no new one while eeprom writes
      if ((r.mode == fsp_pkg::FSP_IDLE) && !eeprom_write_busy && legal_cmd(pwdata[4:0])) begin
        r_nxt.mode = fsp_pkg::FSP_ARMED; // RL5 RL20
        r_nxt.cmd = pwdata[4:0];
        r_nxt.arm_cnt = fsp_pkg::STORE_WINDOW; // RL1
        r_nxt.lpm_cnt = (pwdata[4:0] == fsp_pkg::CMD_LOCK) ? fsp_pkg::LOAD_WINDOW : 2'h0; // RL21
      end
    end
    case (r.mode)
      fsp_pkg::FSP_ARMED: begin
        if (r.lpm_cnt != 2'h0) begin
          r_nxt.lpm_cnt = r.lpm_cnt - 2'h1;
        end
        if (lpm_ok) begin
          r_nxt.lpm_data = readback(r.zptr, r.lock); // RL25 RL26
          r_nxt.lpm_valid = 1'b1;
          r_nxt.mode = fsp_pkg::FSP_IDLE; // RL22
          r_nxt.cmd = fsp_pkg::CMD_NONE;
          r_nxt.arm_cnt = 3'h0;
          r_nxt.lpm_cnt = 2'h0;
        end else if (spm_ok) begin
          r_nxt.arm_cnt = 3'h0;
          r_nxt.lpm_cnt = 2'h0;
          case (r.cmd)
            fsp_pkg::CMD_LOAD: begin
              bif.wr_en = 1'b1; // RL2
              r_nxt.rww_busy = 1'b0; // RL23
              r_nxt.mode = fsp_pkg::FSP_IDLE; // RL4
              r_nxt.cmd = fsp_pkg::CMD_NONE;
            end
            fsp_pkg::CMD_ERASE, fsp_pkg::CMD_WRITE: begin
              // data pair and non-page pointer bits play no part here
              r_nxt.op_page = z_page; // RL7 RL9 RL14
              r_nxt.op_halt = (z_page >= fsp_pkg::HALT_FIRST_PAGE); // RL10
              r_nxt.rww_busy = r.rww_busy | (z_page < fsp_pkg::HALT_FIRST_PAGE); // RL16
              r_nxt.erase_start = (r.cmd == fsp_pkg::CMD_ERASE);
              r_nxt.prog_cnt = 20'(PROG_CYCLES); // RL27
              r_nxt.stream_idx = 7'h00;
              r_nxt.mode = fsp_pkg::FSP_PROG; // RL4
            end
            fsp_pkg::CMD_LOCK: begin
              // pointer is not consulted; a zero data bit programs its lock bit
              r_nxt.lock[fsp_pkg::LOCK_HI_POS:fsp_pkg::LOCK_LO_POS] =
                r.lock[fsp_pkg::LOCK_HI_POS:fsp_pkg::LOCK_LO_POS] &
                r.data[fsp_pkg::LOCK_HI_POS:fsp_pkg::LOCK_LO_POS]; // RL8 RL17
              r_nxt.op_halt = 1'b0; // RL19
              r_nxt.prog_cnt = 20'(PROG_CYCLES); // RL27
              r_nxt.mode = fsp_pkg::FSP_PROG;
            end
            fsp_pkg::CMD_REEN: begin
              bif.clr = 1'b1; // RL12 RL24
              r_nxt.rww_busy = 1'b0; // RL16
              r_nxt.mode = fsp_pkg::FSP_IDLE;
              r_nxt.cmd = fsp_pkg::CMD_NONE;
            end
            default: begin
              r_nxt.mode = fsp_pkg::FSP_IDLE;
              r_nxt.cmd = fsp_pkg::CMD_NONE;
            end
          endcase
        end else if (r.arm_cnt <= 3'h1) begin
          r_nxt.mode = fsp_pkg::FSP_IDLE; // RL4 RL22
          r_nxt.cmd = fsp_pkg::CMD_NONE;
          r_nxt.arm_cnt = 3'h0;
          r_nxt.lpm_cnt = 2'h0;
        end else begin
          r_nxt.arm_cnt = r.arm_cnt - 3'h1;
        end
      end
      fsp_pkg::FSP_PROG: begin
        // page write streams the buffer out one word a cycle at its start
        if ((r.cmd == fsp_pkg::CMD_WRITE) && !r.stream_idx[6]) begin
          r_nxt.fl_valid = 1'b1; // RL14
          r_nxt.fl_word = r.stream_idx[5:0];
          r_nxt.fl_data = bif.rd_data;
          r_nxt.stream_idx = r.stream_idx + 7'h01;
        end
        if (r.prog_cnt <= 20'h0_0001) begin
          bif.clr = (r.cmd == fsp_pkg::CMD_WRITE); // RL12
          r_nxt.fl_done = 1'b1;
          r_nxt.op_halt = 1'b0;
          r_nxt.mode = fsp_pkg::FSP_IDLE; // RL27
          r_nxt.cmd = fsp_pkg::CMD_NONE;
        end else begin
          r_nxt.prog_cnt = r.prog_cnt - 20'h0_0001;
        end
      end
      default: begin
      end
    endcase
    r_nxt.irq = r_nxt.irq_en & ~r_nxt.cmd[0]; // RL15
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r <= ST_RESET;
    end else begin
      r <= r_nxt;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign lpm_rdata = r.lpm_data;
  assign lpm_rvalid = r.lpm_valid;
  assign selfprog_irq = r.irq;
  assign cpu_halt = r.op_halt; // RL10
  assign rww_read_block = r.rww_busy; // RL16
  assign flash_erase_start = r.erase_start;
  assign flash_prog_valid = r.fl_valid;
  assign flash_prog_page = r.op_page;
  assign flash_prog_word = r.fl_word;
  assign flash_prog_data = r.fl_data;
  assign flash_prog_done = r.fl_done;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_arm;
    ctl_wr && (r.mode == fsp_pkg::FSP_IDLE) && !eeprom_write_busy && legal_cmd(pwdata[4:0]);
  endsequence
  sequence s_quiet4;
    (!spm_strobe && !lpm_strobe) [*4];
  endsequence

  chk_arm_window: assert property (s_arm |=> (r.mode == fsp_pkg::FSP_ARMED) && // RL1
    (r.arm_cnt == 3'h4)) else $error("store window not armed for four cycles");
  chk_arm_expire: assert property (s_arm ##1 s_quiet4 |=> (r.cmd == fsp_pkg::CMD_NONE)) // RL4
    else $error("command survived an empty store window");
  chk_bad_cmd: assert property (ctl_wr && !legal_cmd(pwdata[4:0]) && // RL5
    (r.mode == fsp_pkg::FSP_IDLE) |=> (r.mode == fsp_pkg::FSP_IDLE))
    else $error("illegal command pattern was accepted");
  chk_load_entry: assert property (spm_ok && (r.cmd == fsp_pkg::CMD_LOAD) |-> // RL2
    bif.wr_en && (bif.wr_idx == r.zptr[6:1]) && (bif.wr_data == r.data))
    else $error("buffer load used wrong entry or data");
  chk_page_held: assert property ((r.mode == fsp_pkg::FSP_PROG) ##1 // RL7
    (r.mode == fsp_pkg::FSP_PROG) |-> $stable(r.op_page))
    else $error("latched page moved during an operation");
  // a busy flag left over from an earlier readable-section job stays set, so start from clear
  chk_halt_stall: assert property (spm_ok && (r.cmd == fsp_pkg::CMD_ERASE) && // RL10
    !rww_read_block && (z_page >= fsp_pkg::HALT_FIRST_PAGE) |=>
    (cpu_halt && !rww_read_block) [*2])
    else $error("halting section erase did not stall cpu");
  chk_busy_sticky: assert property (rww_read_block && !spm_ok |=> rww_read_block) // RL16
    else $error("busy flag dropped without re-enable or load");
  chk_lock_nohalt: assert property ((r.mode == fsp_pkg::FSP_PROG) && // RL19
    (r.cmd == fsp_pkg::CMD_LOCK) |-> !cpu_halt)
    else $error("cpu halted while programming lock bits");
  chk_ee_block: assert property (eeprom_write_busy |=> // RL20
    !lpm_rvalid && !flash_erase_start)
    else $error("operation started during eeprom write");
  chk_fuse_low: assert property (lpm_ok && (r.zptr == fsp_pkg::ZSEL_FUSE_LO) |=> // RL25 RL22
    lpm_rvalid && (lpm_rdata == FUSE_LOW_VALUE) && (r.cmd == fsp_pkg::CMD_NONE))
    else $error("fuse low readback wrong");
  chk_irq_level: assert property ($fell(r.cmd[0]) && r.irq_en |-> selfprog_irq) // RL15
    else $error("interrupt not raised when store enable cleared");
  chk_load_busy: assert property (spm_ok && (r.cmd == fsp_pkg::CMD_LOAD) |=> // RL23
    !rww_read_block) else $error("buffer load left the busy flag set");
  chk_reen_clear: assert property (spm_ok && (r.cmd == fsp_pkg::CMD_REEN) |-> // RL12 RL24
    bif.clr ##1 !rww_read_block) else $error("re-enable kept buffer or busy flag");
  chk_lock_bits: assert property (spm_ok && (r.cmd == fsp_pkg::CMD_LOCK) |=> // RL17 RL8
    (r.lock[5:2] == ($past(r.lock[5:2]) & $past(r.data[5:2]))))
    else $error("lock bits not programmed from data bits");
  chk_done_clears: assert property (flash_prog_done |-> // RL27 RL4
    (r.cmd == fsp_pkg::CMD_NONE) && !cpu_halt)
    else $error("command or halt outlived the operation timer");

endmodule : fsp_ctrl
`default_nettype wire

// ---- hdl/fsp_pkg.sv ----
package fsp_pkg;

  // apb register offsets (byte addresses)
  localparam logic [7:0] OFS_CTL = 8'h00;
  localparam logic [7:0] OFS_ZPTR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_LOCK = 8'h0c;

  // control register fields
  localparam int CTL_IRQ_EN_POS = 7;
  localparam int CTL_BUSY_POS = 6;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // low five bits of the control register
  localparam logic [4:0] CMD_NONE = 5'h00;
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_REEN = 5'h11;

  // address pointer split: byte bit, word in page, page select
  localparam int WORD_LSB = 1;
  localparam int WORD_BITS = 6;
  localparam int PAGE_LSB = 7;
  localparam int PAGE_BITS = 7;
  localparam int PAGE_WORDS = 64;
  localparam logic [6:0] HALT_FIRST_PAGE = 7'h70;

  // readback selectors held in the pointer
  localparam logic [15:0] ZSEL_FUSE_LO = 16'h0000;
  localparam logic [15:0] ZSEL_LOCK = 16'h0001;
  localparam logic [15:0] ZSEL_FUSE_HI = 16'h0003;

  // lock byte: bits 5..2 are boot lock bits, unprogrammed reads one
  localparam int LOCK_LO_POS = 2;
  localparam int LOCK_HI_POS = 5;
  localparam logic [7:0] LOCK_RESET = 8'hff;
  localparam logic [15:0] BUF_ERASED = 16'hffff;

  // timing
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [1:0] LOAD_WINDOW = 2'h3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_US = 3700;
  localparam int PROG_CYCLES = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_ARMED = 2'b01,
    FSP_PROG = 2'b10
  } fsp_mode_type;

endpackage : fsp_pkg

// ---- hdl/fsp_buf_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface fsp_buf_if;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [15:0] wr_data;
  logic clr;
  logic [5:0] rd_idx;
  logic [15:0] rd_data;

  modport ctl (output wr_en, output wr_idx, output wr_data, output clr, output rd_idx,
    input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input clr, input rd_idx,
    output rd_data);
endinterface : fsp_buf_if
`default_nettype wire

// ---- hdl/fsp_page_buf.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsp_page_buf (
  input wire logic ref_clk,
  input wire logic rst,
  fsp_buf_if.store bif
);

  typedef struct packed {
    logic [63:0] valid;
  } fsp_buf_state_type;

  fsp_buf_state_type r;
  fsp_buf_state_type r_nxt;
  logic [15:0] mem [0:fsp_pkg::PAGE_WORDS-1];

  // clearing only drops the valid bits, so a full clear costs one cycle
  always_comb begin
    r_nxt = r;
    if (bif.clr) begin
      r_nxt.valid = '0;
    end else if (bif.wr_en) begin
      r_nxt.valid[bif.wr_idx] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (bif.wr_en && !bif.clr) begin
      mem[bif.wr_idx] <= bif.wr_data;
    end
  end

  // an entry never loaded since the last clear reads as erased flash
  assign bif.rd_data = r.valid[bif.rd_idx] ? mem[bif.rd_idx] : fsp_pkg::BUF_ERASED;

endmodule : fsp_page_buf
`default_nettype wire

// ---- verification/fsp_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsp_cpu_model (
  input wire logic ref_clk,
  output logic spm_strobe,
  output logic lpm_strobe
);
  initial begin
    spm_strobe = 1'b0;
    lpm_strobe = 1'b0;
  end
  // instruction is sampled on the n-th edge after the arming write; n past the window is a late cpu
  task automatic issue(input bit is_load, input int n);
    repeat (n - 1) @(posedge ref_clk);
    if (is_load) lpm_strobe <= 1'b1;
    else spm_strobe <= 1'b1;
    @(posedge ref_clk);
    lpm_strobe <= 1'b0;
    spm_strobe <= 1'b0;
  endtask : issue
endmodule : fsp_cpu_model
`default_nettype wire

// ---- verification/tb_flash_self_program_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_flash_self_program_control;
  logic ref_clk, rst, psel, penable, pwrite, eeprom_write_busy, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic spm_strobe, lpm_strobe, lpm_rvalid, selfprog_irq, cpu_halt, rww_read_block;
  logic flash_erase_start, flash_prog_valid, flash_prog_done, last_err;
  logic [7:0] lpm_rdata;
  logic [6:0] flash_prog_page, seen_page;
  logic [5:0] flash_prog_word;
  logic [15:0] flash_prog_data;
  logic [15:0] seen_buf [64];
  logic erase_seen, rv_seen;
  logic [7:0] rd_seen;
  int words_seen, fails, samples_checked, i;
  logic [15:0] rb_ptr [4] = '{16'h0001, 16'h0000, 16'h0003, 16'h0002};
  logic [7:0] rb_exp [4] = '{8'heb, 8'h5a, 8'ha5, 8'hff};
  logic [7:0] bad_cmd [5] = '{8'h87, 8'h8b, 8'h93, 8'h9f, 8'h82};

  // short program time keeps the run small; must stay above the 64 streamed words
  fsp_ctrl #(.PROG_CYCLES(100), .FUSE_LOW_VALUE(8'h5a), .FUSE_HIGH_VALUE(8'ha5)) DUT (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spm_strobe(spm_strobe), .lpm_strobe(lpm_strobe), .eeprom_write_busy(eeprom_write_busy),
    .lpm_rdata(lpm_rdata), .lpm_rvalid(lpm_rvalid), .selfprog_irq(selfprog_irq),
    .cpu_halt(cpu_halt), .rww_read_block(rww_read_block),
    .flash_erase_start(flash_erase_start), .flash_prog_valid(flash_prog_valid),
    .flash_prog_page(flash_prog_page), .flash_prog_word(flash_prog_word),
    .flash_prog_data(flash_prog_data), .flash_prog_done(flash_prog_done));
  fsp_cpu_model cpu (.ref_clk(ref_clk), .spm_strobe(spm_strobe), .lpm_strobe(lpm_strobe));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (flash_prog_valid === 1'b1) begin
      seen_buf[flash_prog_word] <= flash_prog_data;
      words_seen <= words_seen + 1;
      seen_page <= flash_prog_page;
    end
    if (flash_erase_start === 1'b1) begin
      erase_seen <= 1'b1;
      seen_page <= flash_prog_page;
    end
    if (lpm_rvalid === 1'b1) begin
      rv_seen <= 1'b1;
      rd_seen <= lpm_rdata;
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // pready and read data are taken at the rising edge that completes the access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      fails++;
      final_report();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0000_0000);
    check(name, q, exp);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  task automatic wait_done();
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge ref_clk);
      if (flash_prog_done === 1'b1) break;
    end
    if (k == 300) begin
      fails++;
      final_report();
    end
  endtask : wait_done

  task automatic page_write(input int n);
    words_seen = 0;
    // stale words from an earlier page would hide a missing stream
    foreach (seen_buf[j]) seen_buf[j] = 16'h0000;
    wr(8'h04, 32'h0000_01aa);
    wr(8'h00, 32'h0000_0085);
    cpu.issue(1'b0, n);
    wr(8'h04, 32'h0000_0000);
    wait_done();
    check("words", words_seen, 64);
    check("wr_page", {25'h0, seen_page}, 32'h0000_0003);
  endtask : page_write

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    eeprom_write_busy = 1'b0;
    erase_seen = 1'b0;
    rv_seen = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0000_0000, "ctl_rst");
    rd(8'h0c, 32'h0000_00ff, "lock_rst");
    rd(8'h10, 32'h0000_0000, "unmapped");
    check("slverr", {31'h0, last_err}, 32'h0000_0001);
    wr(8'h00, 32'h0000_0080);
    tick(1);
    check("irq_on", {31'h0, selfprog_irq}, 32'h0000_0001);
    foreach (bad_cmd[j]) begin
      wr(8'h00, {24'h0, bad_cmd[j]});
      rd(8'h00, 32'h0000_0080, "bad_cmd");
    end
    // each buffer entry is loaded once between clears
    wr(8'h04, 32'h0000_000b);
    wr(8'h08, 32'h0000_1234);
    wr(8'h00, 32'h0000_0081);
    cpu.issue(1'b0, 4);
    rd(8'h00, 32'h0000_0080, "ld_clr");
    wr(8'h04, 32'h0000_000c);
    wr(8'h08, 32'h0000_5555);
    wr(8'h00, 32'h0000_0081);
    tick(1);
    check("irq_armed", {31'h0, selfprog_irq}, 32'h0000_0000);
    cpu.issue(1'b0, 5);
    rd(8'h00, 32'h0000_0080, "late_clr");
    page_write(1);
    check("w5", seen_buf[5], 32'h0000_1234);
    check("w6", seen_buf[6], 32'h0000_ffff);
    check("w0", seen_buf[0], 32'h0000_ffff);
    check("rww_blk", rww_read_block, 32'h0000_0001);
    check("no_halt", cpu_halt, 32'h0000_0000);
    rd(8'h00, 32'h0000_00c0, "busy_set");
    wr(8'h04, 32'h0000_0012);
    wr(8'h08, 32'h0000_beef);
    wr(8'h00, 32'h0000_0081);
    cpu.issue(1'b0, 2);
    rd(8'h00, 32'h0000_0080, "busy_ld");
    wr(8'h00, 32'h0000_0091);
    cpu.issue(1'b0, 1);
    page_write(3);
    check("w9", seen_buf[9], 32'h0000_ffff);
    check("w5b", seen_buf[5], 32'h0000_ffff);
    wr(8'h00, 32'h0000_0091);
    cpu.issue(1'b0, 1);
    rd(8'h00, 32'h0000_0080, "reen");
    check("rww_free", rww_read_block, 32'h0000_0000);
    wr(8'h04, 32'h0000_387f);
    wr(8'h00, 32'h0000_0083);
    cpu.issue(1'b0, 1);
    tick(2);
    check("erase", {31'h0, erase_seen}, 32'h0000_0001);
    check("er_page", {25'h0, seen_page}, 32'h0000_0070);
    check("halt", cpu_halt, 32'h0000_0001);
    rd(8'h00, 32'h0000_0083, "er_hold");
    wait_done();
    tick(2);
    check("halt_end", cpu_halt, 32'h0000_0000);
    // pointer at the lock selector and unused data bits high
    wr(8'h04, 32'h0000_0001);
    wr(8'h08, 32'h0000_00eb);
    wr(8'h00, 32'h0000_0089);
    cpu.issue(1'b0, 2);
    tick(1);
    check("lk_nohalt", cpu_halt, 32'h0000_0000);
    rd(8'h0c, 32'h0000_00eb, "lock_prog");
    wait_done();
    rd(8'h00, 32'h0000_0080, "lk_done");
    for (i = 0; i < 5; i++) begin
      eeprom_write_busy <= (i == 4);
      wr(8'h04, {16'h0, rb_ptr[i % 4]});
      wr(8'h00, 32'h0000_0089);
      rv_seen = 1'b0;
      cpu.issue(1'b1, 3);
      tick(2);
      check("rb_valid", {31'h0, rv_seen}, {31'h0, i < 4});
      if (i < 4) check("rb_data", {24'h0, rd_seen}, {24'h0, rb_exp[i]});
    end
    eeprom_write_busy <= 1'b0;
    wr(8'h00, 32'h0000_0089);
    rv_seen = 1'b0;
    cpu.issue(1'b1, 4);
    tick(2);
    check("rb_late", {31'h0, rv_seen}, 32'h0000_0000);
    rd(8'h00, 32'h0000_0080, "rb_clr");
    // a word loaded before a mid-run reset must not reach flash
    wr(8'h04, 32'h0000_0002);
    wr(8'h08, 32'h0000_7777);
    wr(8'h00, 32'h0000_0001);
    cpu.issue(1'b0, 1);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h0c, 32'h0000_00ff, "lock_rst2");
    page_write(1);
    check("w1_rst", seen_buf[1], 32'h0000_ffff);
    final_report();
  end
endmodule : tb_flash_self_program_control
`default_nettype wire
